// ### ir_byte_fifo.sv
module ir_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic [WIDTH-1:0]      rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// honest flags from the occupancy count
	assign wr_ready_out = (count < (AW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;

	// storage write
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	// pointers and count
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ir_byte_fifo

// ### ir_far_sink.sv
module ir_far_sink (
	input  wire logic clk_in,
	output logic      ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// far side takes bytes but stalls one cycle in three
	always @(posedge clk_in) begin
		ready_out <= #1 ($urandom % 3) != 0;
	end
endmodule : ir_far_sink

// ### ir_flow_consts.svh
// Summary of operation
// - photodetect crossing wakes from low power
// - reset also wakes into normal operation
// - ten seconds idle re-enters low power
// - open-collector output shows handler activity
// - link rate fixed at 9.6 kbaud
// - host buffer holds at most 29 bytes
// - clear-to-send high at 23 buffered bytes
// - infrared receive blocks at most 64 bytes
// - eight overhead bytes per packet
// - half duplex, never transmit while receiving
// - wait one bit time before transmitting
// - fixed identification string ends with revision
// - disconnected, discovery, connected in order
// - idle disconnected: stop oscillator, flag low
// - accept six more bytes after clear-to-send
`ifndef IR_FLOW_CONSTS_SVH
`define IR_FLOW_CONSTS_SVH
`define CLK_HZ          100000000
`define IDLE_SECONDS    10
`define BAUD_RATE       9600
`define BIT_CYCLES      (`CLK_HZ / `BAUD_RATE)
`define HOST_BUF_BYTES  29
`define CTS_RAISE_BYTES 23
`define CTS_SLACK_BYTES 6
`define IR_BLOCK_BYTES  64
`define MIN_FRAME_BYTES 6
`define OVERHEAD_BYTES  8
`define ID_REVISION     16'h3030 // arbitrary revision characters
`endif

// ### ir_flow_pkg.sv
package ir_flow_pkg;
	typedef enum logic [1:0] {
		disconnected_poll_state  = 2'b00,
		discovery_state          = 2'b01,
		connected_exchange_state = 2'b10,
		low_power_state          = 2'b11
	} link_state_t;
endpackage : ir_flow_pkg

// ### ir_secondary_power_and_flow.sv
`include "ir_flow_consts.svh"
module ir_secondary_power_and_flow #(
	parameter int IDLE_CYCLES = `CLK_HZ * `IDLE_SECONDS
) (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       photodetect_in,
	input  wire logic       photodetect_reference_in,
	input  wire logic       ir_rx_active_in,
	input  wire logic       discovery_done_in,
	input  wire logic       link_closed_in,
	input  wire logic       host_rts_in,
	input  wire logic [7:0] host_data_in,
	input  wire logic       host_valid_in,
	output logic            host_ready_out,
	input  wire logic       ir_tx_request_in,
	output logic            ir_tx_grant_out,
	output logic [7:0]      ir_payload_out,
	output logic            ir_payload_valid_out,
	input  wire logic       ir_payload_ready_in,
	input  wire logic       ir_drain_in,
	output logic            host_cts_out,
	output logic            protocol_active_out,
	output logic            protocol_active_oe_out,
	output logic            oscillator_enable_out,
	output logic            link_up_out,
	output logic [1:0]      link_state_out,
	output logic [15:0]     device_revision_out
);
	ir_flow_pkg::link_state_t state;
	ir_flow_pkg::link_state_t next_state;
	logic [31:0] idle_count;
	logic [5:0]  host_fill;
	logic [15:0] turn_count;
	logic        activity;
	logic        idle_expired;
	logic        fifo_ready;
	logic        host_push;
	logic        host_pop;
	logic        cts;
	logic        leaving;
	logic [6:0]  packet_len;

	// room test shared by the host handshake and the fifo write
	function automatic logic host_has_room(input logic [5:0] fill);
		return fill < 6'(`HOST_BUF_BYTES);
	endfunction : host_has_room

	// state test shared by timer, grant and guards
	function automatic logic is_asleep(input ir_flow_pkg::link_state_t s);
		return s == ir_flow_pkg::low_power_state;
	endfunction : is_asleep

	// comparator output stands in for the analog crossing
	assign activity     = (photodetect_in ^ photodetect_reference_in) | ir_rx_active_in;
	assign idle_expired = (idle_count >= 32'(IDLE_CYCLES) - 32'h1);
	assign leaving      = (state != next_state);

	always_ff @(posedge clk_in) begin
		if (reset_in || activity || is_asleep(state) || leaving) begin
			idle_count <= '0; // each phase gets its own full idle span
		end else if (!idle_expired) begin
			idle_count <= idle_count + 32'h1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ir_flow_pkg::low_power_state: begin
				if (activity) begin
					next_state = ir_flow_pkg::disconnected_poll_state;
				end
			end
			ir_flow_pkg::disconnected_poll_state: begin
				if (idle_expired) begin
					next_state = ir_flow_pkg::low_power_state;
				end else if (discovery_done_in) begin
					next_state = ir_flow_pkg::discovery_state;
				end
			end
			ir_flow_pkg::discovery_state: begin
				if (idle_expired) begin
					next_state = ir_flow_pkg::disconnected_poll_state;
				end else if (discovery_done_in) begin
					next_state = ir_flow_pkg::connected_exchange_state;
				end
			end
			ir_flow_pkg::connected_exchange_state: begin
				if (link_closed_in || idle_expired) begin
					next_state = ir_flow_pkg::disconnected_poll_state;
				end
			end
			default: next_state = ir_flow_pkg::disconnected_poll_state;
		endcase
	end

	// reset wakes; idle sleep via timer
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= ir_flow_pkg::disconnected_poll_state;
		end else begin
			state <= next_state;
		end
	end

	assign protocol_active_out    = 1'b0;
	assign protocol_active_oe_out = (state == ir_flow_pkg::low_power_state);
	assign oscillator_enable_out  = (state != ir_flow_pkg::low_power_state);
	assign link_state_out         = state;
	assign device_revision_out    = `ID_REVISION;

	// registered link flag
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			link_up_out <= 1'b0;
		end else begin
			link_up_out <= (next_state == ir_flow_pkg::connected_exchange_state);
		end
	end

	assign host_push      = host_valid_in && host_ready_out;
	assign host_pop       = ir_drain_in && host_fill != '0;
	// slack bytes still taken after cts
	assign host_ready_out = host_has_room(host_fill) && fifo_ready;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			host_fill <= '0;
		end else begin
			host_fill <= host_fill + 6'(host_push) - 6'(host_pop);
		end
	end

	// raise at 23; outside connected the host is held off
	assign cts = (host_fill >= 6'(`CTS_RAISE_BYTES))
		|| (state != ir_flow_pkg::connected_exchange_state);
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			host_cts_out <= 1'b1;
		end else begin
			host_cts_out <= cts;
		end
	end

	// eight overhead bytes ride with each host block
	assign packet_len = 7'(host_fill) + 7'(`OVERHEAD_BYTES);

	// bit time from the fixed link rate
	// transmit only after receive idles; one bit time gap
	always_ff @(posedge clk_in) begin
		if (reset_in || ir_rx_active_in) begin
			turn_count <= 16'(`BIT_CYCLES);
		end else if (turn_count != '0) begin
			turn_count <= turn_count - 16'h1;
		end
	end
	assign ir_tx_grant_out = ir_tx_request_in && !ir_rx_active_in && turn_count == '0
		&& !is_asleep(state);

	// small staging fifo between host and packetiser
	ir_byte_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
		.clk_in       (clk_in),
		.reset_in     (reset_in),
		.wr_data_in   (host_data_in),
		.wr_valid_in  (host_valid_in && host_has_room(host_fill)),
		.wr_ready_out (fifo_ready),
		.rd_data_out  (ir_payload_out),
		.rd_valid_out (ir_payload_valid_out),
		.rd_ready_in  (ir_payload_ready_in)
	);

	// guards on this block's own state and outputs, all on the device clock
	// threshold raises cts
	a_cts_threshold: assert property (
		@(posedge clk_in) disable iff (reset_in)
		host_fill >= 6'(`CTS_RAISE_BYTES) |=> host_cts_out
	) else $error("cts low at threshold");

	a_buffer_limit: assert property (
		@(posedge clk_in) disable iff (reset_in)
		host_fill <= 6'(`HOST_BUF_BYTES)
	) else $error("host buffer overfilled");

	a_half_duplex: assert property (
		@(posedge clk_in) disable iff (reset_in)
		ir_rx_active_in |-> !ir_tx_grant_out
	) else $error("tx during rx");

	a_turn_gap: assert property (
		@(posedge clk_in) disable iff (reset_in)
		$fell(ir_rx_active_in) |-> !ir_tx_grant_out [*8]
	) else $error("turnaround short");

	a_wake_photo: assert property (
		@(posedge clk_in) disable iff (reset_in)
		is_asleep(state) && activity |=> oscillator_enable_out
	) else $error("no wake on crossing");

	a_reset_wake: assert property (
		@(posedge clk_in)
		reset_in |=> state == ir_flow_pkg::disconnected_poll_state
	) else $error("reset did not wake");

	a_sleep_flag: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!oscillator_enable_out |-> protocol_active_oe_out
	) else $error("flag not low asleep");

	a_idle_restart: assert property (
		@(posedge clk_in) disable iff (reset_in)
		activity |=> idle_count == 32'h0
	) else $error("timer not restarted");

	a_ready_full: assert property (
		@(posedge clk_in) disable iff (reset_in)
		host_fill == 6'(`HOST_BUF_BYTES) |-> !host_ready_out
	) else $error("ready while full");

	a_fill_hold: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!host_push && !host_pop |=> $stable(host_fill)
	) else $error("fill moved without traffic");

	a_fill_step: assert property (
		@(posedge clk_in) disable iff (reset_in)
		host_push && !host_pop |=> host_fill == 6'($past(host_fill) + 6'h1)
	) else $error("fill step wrong");

	a_slack_room: assert property (
		@(posedge clk_in) disable iff (reset_in)
		host_fill >= 6'(`CTS_RAISE_BYTES) && host_has_room(host_fill) && fifo_ready
		|-> host_ready_out
	) else $error("slack byte refused");

	a_cts_low: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::connected_exchange_state
		&& host_fill < 6'(`CTS_RAISE_BYTES) |=> !host_cts_out
	) else $error("cts stuck high");

	a_cts_held: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state != ir_flow_pkg::connected_exchange_state |=> host_cts_out
	) else $error("cts low outside exchange");

	a_osc_sleep: assert property (
		@(posedge clk_in) disable iff (reset_in)
		is_asleep(state) |-> !oscillator_enable_out
	) else $error("oscillator on asleep");

	a_oe_awake: assert property (
		@(posedge clk_in) disable iff (reset_in)
		oscillator_enable_out |-> !protocol_active_oe_out
	) else $error("flag pulled low awake");

	a_grant_sleep: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!oscillator_enable_out |-> !ir_tx_grant_out
	) else $error("grant while asleep");

	a_turn_reload: assert property (
		@(posedge clk_in) disable iff (reset_in)
		ir_rx_active_in |=> turn_count == 16'(`BIT_CYCLES)
	) else $error("turnaround not reloaded");

	a_turn_count: assert property (
		@(posedge clk_in) disable iff (reset_in)
		!ir_rx_active_in && turn_count != 16'h0
		|=> turn_count == $past(turn_count) - 16'h1
	) else $error("turnaround count skipped");

	a_grant_ready: assert property (
		@(posedge clk_in) disable iff (reset_in)
		ir_tx_request_in && !ir_rx_active_in && turn_count == 16'h0 && !is_asleep(state)
		|-> ir_tx_grant_out
	) else $error("grant withheld");

	a_order_poll: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::disconnected_poll_state |=> state inside
		{ir_flow_pkg::disconnected_poll_state, ir_flow_pkg::discovery_state,
		ir_flow_pkg::low_power_state}
	) else $error("polling skipped a phase");

	a_order_disc: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::discovery_state |=> state inside
		{ir_flow_pkg::discovery_state, ir_flow_pkg::connected_exchange_state,
		ir_flow_pkg::disconnected_poll_state}
	) else $error("discovery left wrongly");

	a_order_conn: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::connected_exchange_state |=> state inside
		{ir_flow_pkg::connected_exchange_state, ir_flow_pkg::disconnected_poll_state}
	) else $error("exchange left wrongly");

	a_sleep_entry: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::disconnected_poll_state && idle_expired |=> is_asleep(state)
	) else $error("idle poll did not sleep");

	a_idle_exit: assert property (
		@(posedge clk_in) disable iff (reset_in)
		state == ir_flow_pkg::connected_exchange_state && idle_expired
		|=> state == ir_flow_pkg::disconnected_poll_state
	) else $error("idle exchange held");

	a_stay_asleep: assert property (
		@(posedge clk_in) disable iff (reset_in)
		is_asleep(state) && !activity |=> is_asleep(state)
	) else $error("woke without activity");

	a_link_flag: assert property (
		@(posedge clk_in) disable iff (reset_in)
		link_up_out == (state == ir_flow_pkg::connected_exchange_state)
	) else $error("link flag wrong");

	a_packet_fits: assert property (
		@(posedge clk_in) disable iff (reset_in)
		packet_len <= 7'(`IR_BLOCK_BYTES)
	) else $error("packet exceeds block");
endmodule : ir_secondary_power_and_flow

// ### tb_top.sv
`include "ir_flow_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, reset_in = 1, pd_in = 0, rx_act = 0, disc = 0, valid = 0;
	logic tx_req = 0, drain = 0, rdy, grant, pvalid, pready, cts, act, act_oe;
	logic osc, up, took;
	logic [7:0]  data = 8'h00, pdata;
	logic [1:0]  state;
	logic [15:0] rev;
	logic [7:0]  q[$];
	int          miscompares = 0, check_count = 0, acc = 0, n;
	always #5 clk_in = ~clk_in;
	ir_secondary_power_and_flow #(.IDLE_CYCLES(50)) uut (
		.clk_in(clk_in), .reset_in(reset_in), .photodetect_in(pd_in),
		.photodetect_reference_in(1'b0), .ir_rx_active_in(rx_act),
		.discovery_done_in(disc), .link_closed_in(1'b0), .host_rts_in(1'b0),
		.host_data_in(data), .host_valid_in(valid), .host_ready_out(rdy),
		.ir_tx_request_in(tx_req), .ir_tx_grant_out(grant), .ir_payload_out(pdata),
		.ir_payload_valid_out(pvalid), .ir_payload_ready_in(pready), .ir_drain_in(drain),
		.host_cts_out(cts), .protocol_active_out(act), .protocol_active_oe_out(act_oe),
		.oscillator_enable_out(osc), .link_up_out(up), .link_state_out(state),
		.device_revision_out(rev));
	// far side drains every staged byte, stalling at random about one cycle in three
	ir_far_sink sink (.clk_in(clk_in), .ready_out(pready));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("errors %0d of %0d checks", miscompares, check_count);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic cycles(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : cycles
	// bounded wait for a given link state
	task automatic wait_state(input logic [1:0] s, input int lim);
		n = 0;
		while (state !== s && n < lim) begin
			cycles(1);
			n++;
		end
		check(state, s);
		if (state !== s) report_and_stop();
	endtask : wait_state
	// payload watcher: sampled mid-cycle so it never races the edge
	always @(negedge clk_in) begin
		if (pvalid && pready) begin
			if (q.size() == 0) check(1, 0);
			else check(pdata, q.pop_front());
		end
	end
	initial begin
		void'($urandom(9606));
		cycles(6);
		reset_in = 0;
		cycles(1);
		check(state, 2'b00);
		check(osc, 1'b1);
		check(rev, 16'h3030);
		tx_req = 1;
		rx_act = 1;
		cycles(2);
		check(grant, 1'b0);
		// photodetect activity keeps the idle timer fed during the gap
		pd_in = 1;
		rx_act = 0;
		cycles(`BIT_CYCLES - 1);
		check(grant, 1'b0);
		cycles(1);
		check(grant, 1'b1);
		tx_req = 0;
		// walk the phases in order
		for (int i = 1; i <= 2; i++) begin
			disc = 1;
			cycles(1);
			disc = 0;
			cycles(1);
			check(state, i[1:0]);
		end
		cycles(1);
		check(cts, 1'b0);
		check(up, 1'b1);
		// host streams for 200 cycles; fill stops at 29
		valid = 1;
		data = 8'($urandom);
		for (int i = 0; i < 200; i++) begin
			@(negedge clk_in);
			took = rdy;
			cycles(1);
			if (took) begin
				q.push_back(data);
				acc++;
				data = 8'($urandom);
			end
		end
		// host stays silent while clear-to-send is high
		valid = 0;
		check(16'(acc), 16'd29);
		check(cts, 1'b1);
		// drain seven bytes: fill falls to 22, clear-to-send drops
		drain = 1;
		cycles(7);
		drain = 0;
		cycles(2);
		check(cts, 1'b0);
		pd_in = 0;
		cycles(35);
		rx_act = 1;
		cycles(1);
		rx_act = 0;
		cycles(30);
		check(state, 2'b10);
		wait_state(2'b00, 100);
		check(up, 1'b0);
		wait_state(2'b11, 100);
		check(osc, 1'b0);
		check(act_oe, 1'b1);
		pd_in = 1;
		cycles(3);
		pd_in = 0;
		check(osc, 1'b1);
		wait_state(2'b11, 200);
		reset_in = 1;
		cycles(2);
		reset_in = 0;
		cycles(1);
		check(osc, 1'b1);
		check(act_oe, 1'b0);
		check(16'(q.size()), 16'd0);
		report_and_stop();
	end
endmodule : tb_top
